// File: src/ssf_pkg.sv
package ssf_pkg;

    // Register port widths
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // Register addresses
    localparam logic [6:0] ADDR_FRAMES_LO = 7'h46;
    localparam logic [6:0] ADDR_FRAMES_HI = 7'h47;
    localparam logic [6:0] ADDR_OVERHEAD  = 7'h49;
    localparam logic [6:0] ADDR_OUT_LOG2  = 7'h4A;
    localparam logic [6:0] ADDR_LINES_LO  = 7'h4B;
    localparam logic [6:0] ADDR_LINES_HI  = 7'h4C;
    localparam logic [6:0] ADDR_BIT_MODE  = 7'h4D;
    localparam logic [6:0] ADDR_STATUS    = 7'h50;

    // Values after reset
    localparam logic [7:0]  OVERHEAD_RST = 8'h14;
    localparam logic [15:0] FRAMES_RST   = 16'h0001;
    localparam logic [2:0]  OUT_LOG2_RST = 3'h4;
    localparam logic [15:0] LINES_RST    = 16'h0800;
    localparam logic        BIT_MODE_RST = 1'b0;

    // Read-out arithmetic, in master clock periods
    localparam logic [16:0] TICKS_PER_UNIT = 17'h00081;
    localparam logic [2:0]  OUT_LOG2_MAX   = 3'h4;

    // Master clock derived from the system clock; never faster than the
    // 10-bit ceiling, which also keeps it above the lower limit
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned MCLK_MAX_MHZ = 48;
    localparam logic [7:0]  MCLK_DIV     =
        8'((CLK_MHZ + MCLK_MAX_MHZ - 1) / MCLK_MAX_MHZ);

    // Status register bit positions
    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_FOT     = 1;
    localparam int unsigned ST_READOUT = 2;
    localparam int unsigned ST_BIT12   = 3;

    typedef struct packed {
        logic [15:0] frames;
        logic [7:0]  overhead;
        logic [2:0]  out_log2;
        logic [15:0] lines;
        logic        bit12;
    } ssf_cfg_t;

    localparam ssf_cfg_t CFG_RST = '{
        frames:   FRAMES_RST,
        overhead: OVERHEAD_RST,
        out_log2: OUT_LOG2_RST,
        lines:    LINES_RST,
        bit12:    BIT_MODE_RST
    };

    typedef enum logic [1:0] {
        SSF_IDLE,
        SSF_OVERHEAD,
        SSF_READOUT
    } ssf_state_t;

endpackage : ssf_pkg

// File: src/ssf_tick_timer.sv
module ssf_tick_timer (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic        load_i,
    input  wire logic [16:0] load_val_i,
    output logic             done_o
);

    logic [16:0] count_q;
    logic [16:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load_i) begin
            count_d = load_val_i;
        end else if (tick_i && (count_q != 17'h00000)) begin
            count_d = count_q - 17'h00001;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= 17'h00000;
        end else begin
            count_q <= count_d;
        end
    end

    // Done marks the master tick that ends the loaded interval
    assign done_o = tick_i && (count_q == 17'h00001);

endmodule : ssf_tick_timer

// File: src/ssf_sequencer.sv
module ssf_sequencer (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        system_reset_low_i,
    input  wire logic        frame_request_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             busy_o,
    output logic             overhead_o,
    output logic             readout_o,
    output logic             line_done_o,
    output logic             frame_done_o,
    output logic             bit12_mode_o
);

    // Pin synchronisers: the first stage feeds only the second
    logic rstn_s1_q;
    logic rstn_s2_q;
    logic req_s1_q;
    logic req_s2_q;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rstn_s1_q <= 1'b0;
            rstn_s2_q <= 1'b0;
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
        end else begin
            rstn_s1_q <= system_reset_low_i;
            rstn_s2_q <= rstn_s1_q;
            req_s1_q  <= frame_request_i;
            req_s2_q  <= req_s1_q;
        end
    end

    // Master clock enable and pin sampling on its edge
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       tick_q;
    logic       tick_d;
    logic       rstn_smp_q;
    logic       rstn_smp_d;
    logic       req_smp_q;
    logic       req_smp_d;

    always_comb begin
        div_d      = div_q + 8'h01;
        tick_d     = 1'b0;
        rstn_smp_d = rstn_smp_q;
        req_smp_d  = req_smp_q;
        if (div_q == ssf_pkg::MCLK_DIV - 8'h01) begin
            div_d  = 8'h00;
            tick_d = 1'b1;
        end
        if (tick_q) begin
            rstn_smp_d = rstn_s2_q;
            req_smp_d  = req_s2_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_q      <= 8'h00;
            tick_q     <= 1'b0;
            rstn_smp_q <= 1'b0;
            req_smp_q  <= 1'b0;
        end else begin
            div_q      <= div_d;
            tick_q     <= tick_d;
            rstn_smp_q <= rstn_smp_d;
            req_smp_q  <= req_smp_d;
        end
    end

    // Held low the pin keeps the registers and the sequencer at defaults, so the falling edge
    // and the whole low phase act alike
    logic soft_rst;
    logic req_seen;

    assign soft_rst = !rstn_smp_q;
    // Rising edge only: a request held for many periods starts one burst
    assign req_seen = tick_q && req_s2_q && !req_smp_q;

    // Programming registers
    ssf_pkg::ssf_cfg_t cfg_q;
    ssf_pkg::ssf_cfg_t cfg_d;

    always_comb begin
        cfg_d = cfg_q;
        if (soft_rst) begin
            cfg_d = ssf_pkg::CFG_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ssf_pkg::ADDR_FRAMES_LO: cfg_d.frames[7:0]  = reg_wdata_i;
                ssf_pkg::ADDR_FRAMES_HI: cfg_d.frames[15:8] = reg_wdata_i;
                ssf_pkg::ADDR_OVERHEAD:  cfg_d.overhead     = reg_wdata_i;
                ssf_pkg::ADDR_OUT_LOG2: begin
                    if (reg_wdata_i[2:0] > ssf_pkg::OUT_LOG2_MAX) begin
                        cfg_d.out_log2 = ssf_pkg::OUT_LOG2_MAX;
                    end else begin
                        cfg_d.out_log2 = reg_wdata_i[2:0];
                    end
                end
                ssf_pkg::ADDR_LINES_LO:  cfg_d.lines[7:0]   = reg_wdata_i;
                ssf_pkg::ADDR_LINES_HI:  cfg_d.lines[15:8]  = reg_wdata_i;
                ssf_pkg::ADDR_BIT_MODE:  cfg_d.bit12        = reg_wdata_i[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= ssf_pkg::CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Interval lengths from the live configuration
    logic [2:0]  lane_shift;
    logic [4:0]  lane_factor;
    logic [9:0]  fot_units;
    logic [16:0] fot_ticks;
    logic [16:0] line_ticks;

    always_comb begin
        lane_shift  = ssf_pkg::OUT_LOG2_MAX - cfg_q.out_log2;
        lane_factor = 5'(5'h01 << lane_shift);
        fot_units   = {2'b00, cfg_q.overhead} + {4'h0, lane_factor, 1'b0};
        fot_ticks   = 17'({7'h00, fot_units} * ssf_pkg::TICKS_PER_UNIT);
        line_ticks  = 17'({12'h000, lane_factor} * ssf_pkg::TICKS_PER_UNIT);
    end

    // Frame sequencer
    ssf_pkg::ssf_state_t state_q;
    ssf_pkg::ssf_state_t state_d;
    logic [15:0] frames_left_q;
    logic [15:0] frames_left_d;
    logic [15:0] lines_left_q;
    logic [15:0] lines_left_d;
    logic        tmr_load;
    logic [16:0] tmr_val;
    logic        tmr_done;
    logic        line_pulse_d;
    logic        frame_pulse_d;

    ssf_tick_timer u_timer (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .done_o     (tmr_done)
    );

    always_comb begin
        state_d       = state_q;
        frames_left_d = frames_left_q;
        lines_left_d  = lines_left_q;
        tmr_load      = 1'b0;
        tmr_val       = fot_ticks;
        line_pulse_d  = 1'b0;
        frame_pulse_d = 1'b0;
        case (state_q)
            ssf_pkg::SSF_IDLE: begin
                if (req_seen && !soft_rst) begin
                    state_d  = ssf_pkg::SSF_OVERHEAD;
                    tmr_load = 1'b1;
                    tmr_val  = fot_ticks;
                    // A zero count still yields one frame
                    if (cfg_q.frames == 16'h0000) begin
                        frames_left_d = 16'h0001;
                    end else begin
                        frames_left_d = cfg_q.frames;
                    end
                end
            end
            ssf_pkg::SSF_OVERHEAD: begin
                if (tmr_done) begin
                    state_d  = ssf_pkg::SSF_READOUT;
                    tmr_load = 1'b1;
                    tmr_val  = line_ticks;
                    if (cfg_q.lines == 16'h0000) begin
                        lines_left_d = 16'h0001;
                    end else begin
                        lines_left_d = cfg_q.lines;
                    end
                end
            end
            ssf_pkg::SSF_READOUT: begin
                if (tmr_done) begin
                    line_pulse_d = 1'b1;
                    if (lines_left_q == 16'h0001) begin
                        frame_pulse_d = 1'b1;
                        if (frames_left_q == 16'h0001) begin
                            state_d = ssf_pkg::SSF_IDLE;
                        end else begin
                            // Exposure overlaps read-out, so the next
                            // overhead follows at once
                            frames_left_d = frames_left_q - 16'h0001;
                            state_d       = ssf_pkg::SSF_OVERHEAD;
                            tmr_load      = 1'b1;
                            tmr_val       = fot_ticks;
                        end
                    end else begin
                        lines_left_d = lines_left_q - 16'h0001;
                        tmr_load     = 1'b1;
                        tmr_val      = line_ticks;
                    end
                end
            end
            default: begin
                state_d = ssf_pkg::SSF_IDLE;
            end
        endcase
        if (soft_rst) begin
            state_d       = ssf_pkg::SSF_IDLE;
            frames_left_d = 16'h0000;
            lines_left_d  = 16'h0000;
            line_pulse_d  = 1'b0;
            frame_pulse_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q       <= ssf_pkg::SSF_IDLE;
            frames_left_q <= 16'h0000;
            lines_left_q  <= 16'h0000;
        end else begin
            state_q       <= state_d;
            frames_left_q <= frames_left_d;
            lines_left_q  <= lines_left_d;
        end
    end

    // Registered outputs and read port
    logic [7:0] status;
    logic [7:0] rdata_d;

    always_comb begin
        status                      = 8'h00;
        status[ssf_pkg::ST_BUSY]    = (state_q != ssf_pkg::SSF_IDLE);
        status[ssf_pkg::ST_FOT]     = (state_q == ssf_pkg::SSF_OVERHEAD);
        status[ssf_pkg::ST_READOUT] = (state_q == ssf_pkg::SSF_READOUT);
        status[ssf_pkg::ST_BIT12]   = cfg_q.bit12;
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ssf_pkg::ADDR_FRAMES_LO: rdata_d = cfg_q.frames[7:0];
                ssf_pkg::ADDR_FRAMES_HI: rdata_d = cfg_q.frames[15:8];
                ssf_pkg::ADDR_OVERHEAD:  rdata_d = cfg_q.overhead;
                ssf_pkg::ADDR_OUT_LOG2:  rdata_d = {5'h00, cfg_q.out_log2};
                ssf_pkg::ADDR_LINES_LO:  rdata_d = cfg_q.lines[7:0];
                ssf_pkg::ADDR_LINES_HI:  rdata_d = cfg_q.lines[15:8];
                ssf_pkg::ADDR_BIT_MODE:  rdata_d = {7'h00, cfg_q.bit12};
                ssf_pkg::ADDR_STATUS:    rdata_d = status;
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 8'h00;
            busy_o       <= 1'b0;
            overhead_o   <= 1'b0;
            readout_o    <= 1'b0;
            line_done_o  <= 1'b0;
            frame_done_o <= 1'b0;
            bit12_mode_o <= 1'b0;
        end else begin
            reg_rdata_o  <= rdata_d;
            busy_o       <= (state_d != ssf_pkg::SSF_IDLE);
            overhead_o   <= (state_d == ssf_pkg::SSF_OVERHEAD);
            readout_o    <= (state_d == ssf_pkg::SSF_READOUT);
            line_done_o  <= line_pulse_d;
            frame_done_o <= frame_pulse_d;
            bit12_mode_o <= cfg_d.bit12;
        end
    end

endmodule : ssf_sequencer

// File: bench/ssf_ctrl_model.sv
module ssf_ctrl_model (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic reset_cmd_i,
    input  wire logic issue_i,
    output logic      system_reset_low_o,
    output logic      frame_request_o,
    output logic      ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // 1us at 250 MHz, rounded up to whole cycles; pulses span two master periods
    localparam int unsigned WAIT_1US = 250;
    localparam int unsigned HOLD     = 12;
    int unsigned low_cnt;
    int unsigned wait_cnt;
    int unsigned req_cnt;
    logic        pend;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            // Supplies count as stable once the bench lets go of reset
            low_cnt  <= WAIT_1US;
            wait_cnt <= WAIT_1US;
            req_cnt  <= 0;
            pend     <= 1'b0;
        end else begin
            if (reset_cmd_i) begin
                low_cnt  <= HOLD;
                wait_cnt <= WAIT_1US;
            end else if (low_cnt != 0) begin
                low_cnt <= low_cnt - 1;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
            if (req_cnt != 0) begin
                req_cnt <= req_cnt - 1;
            end
            if (issue_i) begin
                pend <= 1'b1;
            end else if (pend && ready_o && req_cnt == 0) begin
                req_cnt <= HOLD;
                pend    <= 1'b0;
            end
        end
    end
    assign system_reset_low_o = (low_cnt == 0);
    assign frame_request_o    = (req_cnt != 0);
    // No gain register here, so an upload needs no settling beyond the 1us wait
    assign ready_o            = (low_cnt == 0) && (wait_cnt == 0);
endmodule : ssf_ctrl_model

// File: bench/ssf_sequencer_assertions.sv
module ssf_checker (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       system_reset_low_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       busy_o,
    input wire logic       overhead_o,
    input wire logic       readout_o,
    input wire logic       line_done_o,
    input wire logic       frame_done_o,
    input wire logic       bit12_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Long enough for the two sync flops plus one master tick
    sequence pin_held_low;
        (!system_reset_low_i) [*8] ##1 (!system_reset_low_i) [*4];
    endsequence
    sequence status_read;
        reg_rd_i && reg_addr_i == ssf_pkg::ADDR_STATUS;
    endsequence
    a_status_mirror: assert property (status_read |=>
        reg_rdata_o[3:0] == {$past(bit12_mode_o), $past(readout_o), $past(overhead_o),
        $past(busy_o)}) else $error("status read does not mirror the phase outputs");
    a_frame_line: assert property (frame_done_o |-> line_done_o)
        else $error("frame end without line end");
    a_phase_excl: assert property (!(overhead_o && readout_o))
        else $error("overhead and read-out overlap");
    a_phase_busy: assert property ((overhead_o || readout_o) |-> busy_o)
        else $error("phase active while not busy");
    a_start_overhead: assert property ($rose(busy_o) |-> overhead_o && !readout_o)
        else $error("frame did not open with overhead");
    a_fot_readout: assert property ($fell(overhead_o) && busy_o |-> readout_o)
        else $error("overhead not followed by read-out");
    a_line_readout: assert property (line_done_o |-> $past(readout_o))
        else $error("line end outside read-out");
    a_line_single: assert property (line_done_o |=> !line_done_o)
        else $error("line pulses back to back");
    a_reset_idle: assert property (pin_held_low |-> !busy_o && !line_done_o)
        else $error("sequencer runs while reset pin held");
    a_reset_mode: assert property (pin_held_low |-> !bit12_mode_o)
        else $error("bit mode not at default while reset pin held");
endmodule : ssf_checker
bind ssf_sequencer ssf_checker i_checker (.clock_i, .rst_i, .system_reset_low_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .busy_o, .overhead_o, .readout_o, .line_done_o, .frame_done_o,
    .bit12_mode_o);

// File: bench/ssf_sequencer_tb_top.sv
module ssf_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] rback;
        logic [7:0] dflt;
    } ssf_row_t;
    localparam int LIMIT = 25000;
    localparam int LINE  = int'(ssf_pkg::TICKS_PER_UNIT) * int'(ssf_pkg::MCLK_DIV);
    // Out_log2 clamps at 4; status is read-only and shows bit mode in bit 3
    ssf_row_t rows [9] = '{
        '{ssf_pkg::ADDR_OVERHEAD, 8'h03, 8'h03, 8'h14},
        '{ssf_pkg::ADDR_OUT_LOG2, 8'h07, 8'h04, 8'h04},
        '{ssf_pkg::ADDR_FRAMES_LO, 8'h00, 8'h00, 8'h01},
        '{ssf_pkg::ADDR_FRAMES_HI, 8'h01, 8'h01, 8'h00},
        '{ssf_pkg::ADDR_LINES_LO, 8'h05, 8'h05, 8'h00},
        '{ssf_pkg::ADDR_LINES_HI, 8'h00, 8'h00, 8'h08},
        '{ssf_pkg::ADDR_BIT_MODE, 8'h01, 8'h01, 8'h00},
        '{7'h10, 8'hAA, 8'h00, 8'h00},
        '{ssf_pkg::ADDR_STATUS, 8'hFF, 8'h08, 8'h00}};
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       issue = 1'b0;
    logic       reset_cmd = 1'b0;
    logic [7:0] reg_rdata;
    logic       busy, overhead, readout, line_done, frame_done, bit12_mode;
    logic       system_reset_low, frame_request, ready;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         ov_cnt, ro_cnt, ln_cnt, fr_cnt;
    always #2 clock = ~clock;
    ssf_ctrl_model i_ctrl (.clock_i(clock), .rst_i(rst), .reset_cmd_i(reset_cmd),
        .issue_i(issue), .system_reset_low_o(system_reset_low),
        .frame_request_o(frame_request), .ready_o(ready));
    ssf_sequencer i_dut (.clock_i(clock), .rst_i(rst), .system_reset_low_i(system_reset_low),
        .frame_request_i(frame_request), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .busy_o(busy),
        .overhead_o(overhead), .readout_o(readout), .line_done_o(line_done),
        .frame_done_o(frame_done), .bit12_mode_o(bit12_mode));
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end
    always @(posedge clock) begin
        ov_cnt += int'(overhead === 1'b1);
        ro_cnt += int'(readout === 1'b1);
        ln_cnt += int'(line_done === 1'b1);
        fr_cnt += int'(frame_done === 1'b1);
    end
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk_val
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        chk_val("read data", 32'(exp), 32'(reg_rdata));
    endtask : rd_chk
    task automatic wait_sig(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk_val("busy", 32'(lvl), 32'(busy));
    endtask : wait_sig
    task automatic pulse_issue();
        @(posedge clock);
        issue <= 1'b1;
        @(posedge clock);
        issue <= 1'b0;
    endtask : pulse_issue
    task automatic cfg(input logic [7:0] fr, input logic [7:0] ln, input logic [7:0] ov,
                       input logic [7:0] l2);
        wr_reg(ssf_pkg::ADDR_FRAMES_LO, fr);
        wr_reg(ssf_pkg::ADDR_FRAMES_HI, 8'h00);
        wr_reg(ssf_pkg::ADDR_LINES_LO, ln);
        wr_reg(ssf_pkg::ADDR_LINES_HI, 8'h00);
        wr_reg(ssf_pkg::ADDR_OVERHEAD, ov);
        wr_reg(ssf_pkg::ADDR_OUT_LOG2, l2);
    endtask : cfg
    // Units are whole lines at 16 outputs; a second request mid-frame must be ignored
    task automatic run_frame(input int ov_u, input int ro_u, input int lines, input int frames);
        logic in_range;
        @(negedge clock);
        ov_cnt = 0;
        ro_cnt = 0;
        ln_cnt = 0;
        fr_cnt = 0;
        pulse_issue();
        wait_sig(1'b1, 100);
        repeat (300) @(posedge clock);
        pulse_issue();
        wait_sig(1'b0, 12000);
        repeat (400) @(negedge clock);
        chk_val("overhead cycles", ov_u * LINE, ov_cnt);
        chk_val("readout cycles", ro_u * LINE, ro_cnt);
        // 4 ns cycles per master period against the 48 MHz and 5 MHz limits
        in_range = (ov_cnt * 4 * 48 >= ov_u * 129 * 1000) && (ov_cnt * 4 * 5 <= ov_u * 129 * 1000);
        chk_val("master clock rate", 1, 32'(in_range));
        chk_val("line pulses", lines, ln_cnt);
        chk_val("frame pulses", frames, fr_cnt);
    endtask : run_frame
    task automatic check_defaults();
        while (ready !== 1'b1) @(negedge clock);
        foreach (rows[i]) rd_chk(rows[i].addr, rows[i].dflt);
        chk_val("bit mode", 0, 32'(bit12_mode));
    endtask : check_defaults
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        check_defaults();
        foreach (rows[i]) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rback);
        end
        chk_val("bit mode", 1, 32'(bit12_mode));
        wr_reg(ssf_pkg::ADDR_BIT_MODE, 8'h00);
        cfg(8'h02, 8'h02, 8'h00, 8'h04);
        run_frame(4, 4, 4, 2);
        cfg(8'h00, 8'h01, 8'h01, 8'h03);
        run_frame(5, 2, 1, 1);
        pulse_issue();
        wait_sig(1'b1, 100);
        @(posedge clock);
        reset_cmd <= 1'b1;
        @(posedge clock);
        reset_cmd <= 1'b0;
        repeat (30) @(negedge clock);
        chk_val("busy after reset", 0, 32'(busy));
        check_defaults();
        conclude();
    end
endmodule : ssf_sequencer_tb_top
